// >>> core/scsi_pio_buffer_controller.sv
// scsi programmed-io byte handshake, memory pio and buffer memory sequencer
// assumes an ahb-lite master, one clock (the buffer clock) and scsi lines
// already synchronous to it
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`include "pio_map.svh"

module scsi_pio_buffer_controller #(
	parameter int IDLE_CYCLES = `IDLE_CYCLES,
	parameter int ADDR_W = 16
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire pio_pkg::scsi_in_t SCSI_I,
	output pio_pkg::scsi_out_t SCSI_O,
	input wire logic [7:0] MEM_DQ_I,
	output pio_pkg::mem_out_t MEM_O,
	input wire logic DISK_MEM_REQ,
	input wire logic DISK_MEM_WRITE,
	input wire logic [15:0] DISK_MEM_ADDR,
	input wire logic [7:0] DISK_WDATA,
	output logic DISK_MEM_DONE,
	output logic [7:0] DISK_RDATA,
	input wire logic SCSI_MEM_BUSY,
	output logic DISK_DIR,
	output logic CMD_DONE_IRQ
);
	if (IDLE_CYCLES < 1 || IDLE_CYCLES > 31 || ADDR_W != 16)
	begin : g_bad_param
		$error("unsupported parameter value");
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	//////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait states, read data prepared in address phase
	logic wr_pend_q;
	logic [7:0] widx_q;
	logic [31:0] rdata_q;
	logic [7:0] sig_q, out_byte_q, cap_q, buf_q, cfg_q;
	logic [15:0] wptr_q, rptr_q;
	logic mem_dir_q, disk_dir_q, scsi_go_q, mem_go_q, done_q;
	logic [7:0] status_w, control_w, bus_now_w;
	logic [31:0] rd_mux_w;
	wire addr_ok = HSEL & HREADY & HTRANS[1];
	wire [7:0] aidx = HADDR[9:2];
	wire clr_done = addr_ok & ~HWRITE & (aidx == `IDX_STATUS);
	wire wr_ctl = wr_pend_q & (widx_q == `IDX_CONTROL);
	pio_pkg::pio_state_t st_q, st_d;
	logic act_q;
	assign status_w = {~act_q ? 1'b0 : 1'b1, 5'h00, done_q,
		st_q != pio_pkg::S_IDLE};
	assign control_w = {mem_go_q, 2'h0, disk_dir_q, 1'b0, scsi_go_q,
		1'b0, mem_dir_q};
	assign bus_now_w = {3'h0, SCSI_I.ack, SCSI_I.req, SCSI_I.msg,
		SCSI_I.cd, SCSI_I.io};
	assign rd_mux_w =
		(aidx == `IDX_STATUS) ? {24'h000000, status_w} :
		(aidx == `IDX_CONTROL) ? {24'h000000, control_w} :
		(aidx == `IDX_SIGNAL) ? {24'h000000, bus_now_w} :
		(aidx == `IDX_CAPTURED) ? {24'h000000, cap_q} :
		(aidx == `IDX_MEM_BYTE) ? {24'h000000, buf_q} :
		(aidx == `IDX_CONFIG) ? {24'h000000, cfg_q} :
		(aidx == `IDX_WR_PTR) ? {16'h0000, wptr_q} :
		(aidx == `IDX_RD_PTR) ? {16'h0000, rptr_q} : 32'h00000000;

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			wr_pend_q <= 1'b0;
			widx_q <= 8'h00;
			rdata_q <= 32'h00000000;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
		end
		else
		begin
			wr_pend_q <= addr_ok & HWRITE;
			widx_q <= aidx;
			rdata_q <= (addr_ok & ~HWRITE) ? rd_mux_w : 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end
	assign HRDATA = rdata_q;

	//////////////////////////////////////////////////////////////////////
	// automatic scsi pio handshake
	logic cap_ev, done_ev, pio_go;
	pio_pkg::scsi_out_t scsi_d, scsi_q;
	wire target = cfg_q[`CF_TARGET];
	wire manual = cfg_q[`CF_MANUAL];
	wire dram = cfg_q[`CF_DRAM];
	// io asserted means target to initiator
	wire sending = target ? sig_q[`SG_IO] : ~sig_q[`SG_IO];
	wire phase_ok = (SCSI_I.io == sig_q[`SG_IO]) &
		(SCSI_I.cd == sig_q[`SG_CD]) & (SCSI_I.msg == sig_q[`SG_MSG]);
	assign pio_go = scsi_go_q & ~manual & (st_q == pio_pkg::S_IDLE);

	// fully interlocked handshake, no offset counting: only async
	always_comb
	begin
		st_d = st_q;
		cap_ev = 1'b0;
		done_ev = 1'b0;
		case (st_q)
			pio_pkg::S_IDLE:
				if (pio_go)
					st_d = target ? pio_pkg::S_TREQ : pio_pkg::S_IWAIT;
			pio_pkg::S_TREQ:
				if (SCSI_I.ack)
				begin
					cap_ev = ~sending;
					st_d = pio_pkg::S_TREL;
				end
			pio_pkg::S_TREL:
				if (!SCSI_I.ack)
					st_d = pio_pkg::S_DONE;
			pio_pkg::S_IWAIT:
				if (SCSI_I.req && phase_ok)
				begin
					cap_ev = ~sending;
					st_d = pio_pkg::S_IACK;
				end
			pio_pkg::S_IACK:
				if (!SCSI_I.req)
					st_d = pio_pkg::S_DONE;
			pio_pkg::S_DONE:
			begin
				done_ev = 1'b1;
				st_d = pio_pkg::S_IDLE;
			end
			default:
				st_d = pio_pkg::S_IDLE;
		endcase
	end

	always_comb
	begin
		scsi_d.data = out_byte_q;
		scsi_d.atn = sig_q[`SG_ATN];
		scsi_d.bsy = sig_q[`SG_BSY];
		scsi_d.sel = sig_q[`SG_SEL];
		if (manual)
		begin
			scsi_d.req = sig_q[`SG_REQ];
			scsi_d.ack = sig_q[`SG_ACK];
			scsi_d.io = sig_q[`SG_IO];
			scsi_d.cd = sig_q[`SG_CD];
			scsi_d.msg = sig_q[`SG_MSG];
			scsi_d.data_oe = sending;
		end
		else
		begin
			scsi_d.req = st_d == pio_pkg::S_TREQ;
			scsi_d.ack = st_d == pio_pkg::S_IACK;
			scsi_d.io = target & sig_q[`SG_IO];
			scsi_d.cd = target & sig_q[`SG_CD];
			scsi_d.msg = target & sig_q[`SG_MSG];
			scsi_d.data_oe = sending & (target ? st_d == pio_pkg::S_TREQ
				: st_d == pio_pkg::S_IACK);
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			st_q <= pio_pkg::S_IDLE;
			scsi_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			scsi_q <= scsi_d;
		end
	end
	assign SCSI_O = scsi_q;

	//////////////////////////////////////////////////////////////////////
	// buffer memory sequencer: four phases per cycle, one idle between
	pio_pkg::mem_kind_t kind_q, kind_d;
	logic [1:0] cyc_q, cyc_d;
	logic act_d, wr_q, wr_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic [4:0] idle_q;
	pio_pkg::mem_out_t mem_d, mem_q;
	logic disk_done_q;
	logic [7:0] disk_rdata_q;
	wire mpu_req = mem_go_q;
	wire any_req = DISK_MEM_REQ | SCSI_MEM_BUSY | mpu_req;
	wire g_disk = ~act_q & DISK_MEM_REQ;
	wire g_mpu = ~act_q & ~DISK_MEM_REQ & mpu_req & ~SCSI_MEM_BUSY;
	// a request landing in a refresh waits for act_q to fall
	wire g_ref = ~act_q & ~any_req & dram &
		(idle_q >= IDLE_CYCLES[4:0]);
	wire last_ph = act_q & (cyc_q == 2'(`MEM_PHASES - 1));
	wire data_ph = act_q & (cyc_q == 2'(`MEM_PHASES - 2));
	wire mpu_end = data_ph & (kind_q == pio_pkg::K_MPU);

	function automatic pio_pkg::mem_out_t mem_drive(input logic act,
		input logic [1:0] ph, input pio_pkg::mem_kind_t kind,
		input logic wr, input logic [15:0] a, input logic [7:0] wd,
		input logic dr);
		pio_pkg::mem_out_t m;
		logic strobe;
		m.addr = (ph == 2'h0) ? a[7:0] : a[15:8];
		m.data = wd;
		strobe = act & (ph == 2'h1 || ph == 2'h2);
		m.addr_latch_strobe = act & ~dr & (ph == 2'h0);
		// dram output stays enabled: early write only
		m.mem_output_enable_n = dr ? 1'b0 : ~(strobe & ~wr);
		m.we_n = ~(strobe & wr & kind != pio_pkg::K_REFR);
		m.data_oe = strobe & wr & kind != pio_pkg::K_REFR;
		if (kind == pio_pkg::K_REFR)
		begin
			m.cas_n = ~(act & dr & ph != 2'h3);
			m.ras_n = ~(strobe & dr);
		end
		else
		begin
			m.ras_n = ~(act & dr & ph != 2'h3);
			m.cas_n = ~(strobe & dr);
		end
		return m;
	endfunction

	always_comb
	begin
		act_d = act_q & ~last_ph;
		cyc_d = act_q ? cyc_q + 2'h1 : 2'h0;
		kind_d = kind_q;
		wr_d = wr_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		if (g_disk)
		begin
			act_d = 1'b1;
			kind_d = pio_pkg::K_DISK;
			wr_d = DISK_MEM_WRITE;
			addr_d = DISK_MEM_ADDR;
			wdata_d = DISK_WDATA;
		end
		else if (g_mpu)
		begin
			act_d = 1'b1;
			kind_d = pio_pkg::K_MPU;
			wr_d = ~mem_dir_q;
			addr_d = mem_dir_q ? rptr_q : wptr_q;
			wdata_d = buf_q;
		end
		else if (g_ref)
		begin
			act_d = 1'b1;
			kind_d = pio_pkg::K_REFR;
			wr_d = 1'b0;
		end
		mem_d = mem_drive(act_d, cyc_d, kind_d, wr_d, addr_d, wdata_d, dram);
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			act_q <= 1'b0;
			cyc_q <= 2'h0;
			kind_q <= pio_pkg::K_DISK;
			wr_q <= 1'b0;
			addr_q <= `RST_PTR;
			wdata_q <= `RST_BYTE;
			idle_q <= 5'h00;
			mem_q <= {8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0};
			disk_done_q <= 1'b0;
			disk_rdata_q <= `RST_BYTE;
		end
		else
		begin
			act_q <= act_d;
			cyc_q <= cyc_d;
			kind_q <= kind_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			idle_q <= any_req ? 5'h00 :
				(idle_q >= IDLE_CYCLES[4:0]) ? idle_q : idle_q + 5'h01;
			mem_q <= mem_d;
			disk_done_q <= data_ph & (kind_q == pio_pkg::K_DISK);
			if (data_ph && kind_q == pio_pkg::K_DISK && !wr_q)
				disk_rdata_q <= MEM_DQ_I;
		end
	end
	assign MEM_O = mem_q;
	assign DISK_MEM_DONE = disk_done_q;
	assign DISK_RDATA = disk_rdata_q;

	//////////////////////////////////////////////////////////////////////
	// registers software sees
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			sig_q <= `RST_BYTE;
			out_byte_q <= `RST_BYTE;
			cap_q <= `RST_BYTE;
			buf_q <= `RST_BYTE;
			cfg_q <= `RST_BYTE;
			wptr_q <= `RST_PTR;
			rptr_q <= `RST_PTR;
			mem_dir_q <= 1'b0;
			disk_dir_q <= 1'b0;
			scsi_go_q <= 1'b0;
			mem_go_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			if (wr_pend_q && widx_q == `IDX_SIGNAL)
				sig_q <= HWDATA[7:0];
			if (wr_pend_q && widx_q == `IDX_OUT_BYTE)
				out_byte_q <= HWDATA[7:0];
			if (wr_pend_q && widx_q == `IDX_CONFIG)
				cfg_q <= HWDATA[7:0];
			if (cap_ev)
				cap_q <= SCSI_I.data;
			if (mpu_end && !wr_q)
				buf_q <= MEM_DQ_I;
			else if (wr_pend_q && widx_q == `IDX_MEM_BYTE)
				buf_q <= HWDATA[7:0];
			if (mpu_end && wr_q)
				wptr_q <= wptr_q + 16'h0001;
			else if (wr_pend_q && widx_q == `IDX_WR_PTR)
				wptr_q <= HWDATA[15:0];
			if (mpu_end && !wr_q)
				rptr_q <= rptr_q + 16'h0001;
			else if (wr_pend_q && widx_q == `IDX_RD_PTR)
				rptr_q <= HWDATA[15:0];
			// start bits ignore writes while their transfer runs
			if (wr_ctl)
			begin
				disk_dir_q <= HWDATA[`CT_DISK_DIR];
				if (!mem_go_q)
					mem_dir_q <= HWDATA[`CT_MEM_DIR];
			end
			if (done_ev)
				scsi_go_q <= 1'b0;
			else if (wr_ctl && !scsi_go_q)
				scsi_go_q <= HWDATA[`CT_SCSI_GO];
			if (mpu_end)
				mem_go_q <= 1'b0;
			else if (wr_ctl && !mem_go_q)
				mem_go_q <= HWDATA[`CT_MEM_GO];
			// set wins over the clear-on-read
			if (done_ev || mpu_end)
				done_q <= 1'b1;
			else if (clr_done)
				done_q <= 1'b0;
		end
	end
	assign DISK_DIR = disk_dir_q;
	assign CMD_DONE_IRQ = done_q;

	//////////////////////////////////////////////////////////////////////
	// checks on what the block drives
	a_ready_out: assert property ($past(RST_N) |-> HREADYOUT)
		else $error("slave not ready after reset");
	a_cycle_len: assert property ($rose(act_q) |-> act_q[*4] ##1 !act_q)
		else $error("memory cycle not four clocks");
	a_disk_first: assert property (!act_q && DISK_MEM_REQ |=>
		act_q && kind_q == pio_pkg::K_DISK)
		else $error("disk request not served first");
	a_mpu_held: assert property (!act_q && SCSI_MEM_BUSY &&
		!DISK_MEM_REQ |=> !act_q)
		else $error("cycle started while scsi owns buffer");
	a_refresh_idle: assert property ($rose(act_q) &&
		kind_q == pio_pkg::K_REFR |-> $past(idle_q) >= IDLE_CYCLES[4:0])
		else $error("refresh before idle count");
	a_scsi_done: assert property (st_q == pio_pkg::S_DONE |=>
		done_q && st_q == pio_pkg::S_IDLE)
		else $error("handshake end without done");
	a_manual_lines: assert property (manual |=>
		SCSI_O.req == $past(sig_q[`SG_REQ]))
		else $error("manual req not following register");
	a_start_clear: assert property (mpu_end |=>
		!mem_go_q && done_q)
		else $error("memory start not cleared");
	c_refresh: cover property ($rose(act_q) && kind_q == pio_pkg::K_REFR);
	c_target: cover property (st_q == pio_pkg::S_TREL);
	c_initiator: cover property (st_q == pio_pkg::S_IACK);
	c_mpu: cover property (mpu_end);
endmodule

// >>> common/pio_map.svh
// register indices, field positions, reset values and counts of the pio block
// assumes the byte address of a register is four times its index
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
`define IDX_STATUS 8'h61
`define IDX_CONTROL 8'h63
`define IDX_SIGNAL 8'h64
`define IDX_OUT_BYTE 8'h65
`define IDX_CAPTURED 8'h67
`define IDX_MEM_BYTE 8'h70
`define IDX_CONFIG 8'h71
`define IDX_WR_PTR 8'h72
`define IDX_RD_PTR 8'h73
`define ST_SCSI_BUSY 0
`define ST_CMD_DONE 1
`define ST_MEM_BUSY 7
`define CT_MEM_DIR 0
`define CT_SCSI_GO 2
`define CT_DISK_DIR 4
`define CT_MEM_GO 7
`define SG_IO 0
`define SG_CD 1
`define SG_MSG 2
`define SG_REQ 3
`define SG_ACK 4
`define SG_ATN 5
`define SG_BSY 6
`define SG_SEL 7
`define CF_TARGET 0
`define CF_MANUAL 1
`define CF_DRAM 2
`define RST_BYTE 8'h00
`define RST_PTR 16'h0000
`define IDLE_CYCLES 16
`define MEM_PHASES 4
`endif

// >>> common/pio_pkg.sv
// types shared by the pio and buffer controller block
// assumes the bus lines are seen asserted-high; pads do the inversion
package pio_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic req;
		logic ack;
		logic io;
		logic cd;
		logic msg;
	} scsi_in_t;
	typedef struct packed {
		logic [7:0] data;
		logic data_oe;
		logic req;
		logic ack;
		logic io;
		logic cd;
		logic msg;
		logic atn;
		logic bsy;
		logic sel;
	} scsi_out_t;
	typedef struct packed {
		logic [7:0] addr;
		logic addr_latch_strobe;
		logic mem_output_enable_n;
		logic we_n;
		logic ras_n;
		logic cas_n;
		logic [7:0] data;
		logic data_oe;
	} mem_out_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_TREQ = 3'h1,
		S_TREL = 3'h2,
		S_IWAIT = 3'h3,
		S_IACK = 3'h4,
		S_DONE = 3'h5
	} pio_state_t;
	typedef enum logic [1:0] {
		K_DISK = 2'h0,
		K_MPU = 2'h1,
		K_REFR = 2'h2
	} mem_kind_t;
endpackage

// >>> tb/scsi_mem_partner.sv
// far side model: scsi initiator answering the target, or target while peer_target is set, plus byte-wide sram or dram
// assumes lines asserted-high; the block acts as target or initiator, in sram or dram mode
`timescale 1ns/10ps

module scsi_mem_partner (
	input wire logic CLK,
	input wire pio_pkg::scsi_out_t so,
	input wire pio_pkg::mem_out_t mo,
	input wire logic [7:0] send_byte,
	input wire logic [3:0] dly,
	input wire logic peer_target,
	input wire logic [2:0] phase,
	output pio_pkg::scsi_in_t si,
	output logic [7:0] got_byte,
	output logic [7:0] dq
);
	logic [7:0] mem [0:65535];
	logic [7:0] lo_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	logic ack_q = 1'b0;
	logic req_q = 1'b0;
	logic served_q = 1'b0;
	wire drive = peer_target ? req_q : ack_q;
	logic [3:0] cnt_q = 4'h0;
	wire [15:0] addr = {mo.addr, lo_q};

	////////////////////////////////////////////////////////////////////////
	// released data lines show the inverse, so a stale byte never matches
	assign si = {drive ? send_byte : ~send_byte, req_q, ack_q,
		peer_target ? phase : {so.io, so.cd, so.msg}};
	assign dq = !mo.mem_output_enable_n ? mem[addr] : ~last_q;

	always @(posedge CLK)
	begin
		if (so.req && !ack_q)
		begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == dly)
			begin
				ack_q <= 1'b1;
				got_byte <= so.data;
				cnt_q <= 4'h0;
			end
		end
		else if (!so.req)
			ack_q <= 1'b0;
		// peer as target: one req per raise of peer_target
		if (!peer_target)
			served_q <= 1'b0;
		else if (so.ack && req_q)
		begin
			req_q <= 1'b0;
			served_q <= 1'b1;
			got_byte <= so.data;
		end
		else if (!served_q && !so.ack)
			req_q <= 1'b1;
		// dram low byte rides with ras alone
		if (mo.addr_latch_strobe || (!mo.ras_n && mo.cas_n))
			lo_q <= mo.addr;
		if (!mo.we_n)
			mem[addr] <= mo.data;
		if (!mo.mem_output_enable_n)
			last_q <= mem[addr];
	end
endmodule

// >>> tb/tb_scsi_pio_buffer_controller.sv
// self-checking bench: ahb-lite register traffic, memory pio, scsi pio
// assumes the partner model stands as scsi initiator or target, and as sram or dram
`timescale 1ns/10ps
`include "pio_map.svh"

module tb_scsi_pio_buffer_controller;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h2;
	wire [31:0] HRDATA;
	wire HREADYOUT;
	pio_pkg::scsi_in_t si;
	pio_pkg::scsi_out_t so;
	pio_pkg::mem_out_t mo;
	logic [7:0] dq;
	logic [7:0] got_byte;
	logic [7:0] send_byte = 8'h00;
	logic [3:0] dly = 4'h1;
	logic peer_target = 1'b0;
	logic [2:0] phase = 3'h0;
	int refr = 0;
	logic DISK_MEM_REQ = 1'b0;
	logic DISK_MEM_WRITE = 1'b0;
	logic [15:0] DISK_MEM_ADDR = 16'h0;
	logic [7:0] DISK_WDATA = 8'h00;
	logic SCSI_MEM_BUSY = 1'b0;
	wire DISK_MEM_DONE;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int mem_m[int];
	logic [31:0] seed = 32'h0D07;
	logic [31:0] rd;
	logic [7:0] b;

	scsi_pio_buffer_controller uut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(), .SCSI_I(si), .SCSI_O(so),
		.MEM_DQ_I(dq), .MEM_O(mo), .DISK_MEM_REQ(DISK_MEM_REQ),
		.DISK_MEM_WRITE(DISK_MEM_WRITE), .DISK_MEM_ADDR(DISK_MEM_ADDR),
		.DISK_WDATA(DISK_WDATA), .DISK_MEM_DONE(DISK_MEM_DONE),
		.DISK_RDATA(), .SCSI_MEM_BUSY(SCSI_MEM_BUSY), .DISK_DIR(),
		.CMD_DONE_IRQ());
	scsi_mem_partner far_end (.CLK(CLK), .so(so), .mo(mo),
		.send_byte(send_byte), .dly(dly), .peer_target(peer_target),
		.phase(phase), .si(si), .got_byte(got_byte), .dq(dq));

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #25 CLK = ~CLK;
	end

	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (!mo.cas_n && mo.ras_n)
			refr <= refr + 1;
		if (cyc == 20000)
		begin
			failures++;
			test_done();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	// one single transfer; the data-phase wait also covers a stalling slave
	task automatic ahb(input bit w, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {22'h0, idx, 2'h0};
		HWRITE <= w;
		do @(posedge CLK); while (!HREADYOUT);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= wd;
		do @(posedge CLK); while (!HREADYOUT);
		r = HRDATA;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] r;
		ahb(1'b1, idx, wd, r);
	endtask

	task automatic poll(input logic [7:0] idx, input int bitn, input bit v);
		int n;
		n = 0;
		do
		begin
			ahb(1'b0, idx, 32'h0, rd);
			n++;
		end
		while (rd[bitn] !== v && n < 60);
		chk("poll", {31'h0, v}, {31'h0, rd[bitn]});
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		ahb(1'b0, `IDX_STATUS, 32'h0, rd);
		chk("status", 32'h0, rd);
		ahb(1'b0, `IDX_CAPTURED, 32'h0, rd);
		chk("captured", 32'h0, rd);
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
		for (int i = 0; i < 3; i++)
		begin
			b = 8'(rnd());
			mem_m[i] = b;
			wr(`IDX_MEM_BYTE, {24'h0, b});
			wr(`IDX_CONTROL, 32'h80);
			poll(`IDX_CONTROL, `CT_MEM_GO, 1'b0);
			poll(`IDX_STATUS, `ST_CMD_DONE, 1'b1);
		end
		ahb(1'b0, `IDX_WR_PTR, 32'h0, rd);
		chk("wptr", 32'h3, rd);
		@(posedge CLK);
		DISK_MEM_REQ <= 1'b1;
		DISK_MEM_WRITE <= 1'b1;
		DISK_MEM_ADDR <= 16'h0105;
		DISK_WDATA <= 8'h5A;
		mem_m[32'h105] = 8'h5A;
		do @(posedge CLK); while (!DISK_MEM_DONE);
		DISK_MEM_REQ <= 1'b0;
		$display("test memory write done");
		for (int i = 0; i < 4; i++)
		begin
			if (i == 3)
				wr(`IDX_RD_PTR, 32'h105);
			wr(`IDX_CONTROL, 32'h81);
			poll(`IDX_CONTROL, `CT_MEM_GO, 1'b0);
			ahb(1'b0, `IDX_MEM_BYTE, 32'h0, rd);
			chk("membyte", mem_m[i == 3 ? 32'h105 : i], rd);
		end
		$display("test memory read done");
		// reads left done set; clear it so each handshake proves its own
		ahb(1'b0, `IDX_STATUS, 32'h0, rd);
		chk("mem done", 32'h1, {31'h0, rd[`ST_CMD_DONE]});
		wr(`IDX_CONFIG, 32'h1);
		wr(`IDX_SIGNAL, 32'h0);
		send_byte <= 8'(rnd());
		wr(`IDX_CONTROL, 32'h04);
		poll(`IDX_STATUS, `ST_CMD_DONE, 1'b1);
		ahb(1'b0, `IDX_CAPTURED, 32'h0, rd);
		chk("captured", {24'h0, send_byte}, rd);
		b = 8'(rnd());
		dly <= 4'h6;
		wr(`IDX_OUT_BYTE, {24'h0, b});
		wr(`IDX_SIGNAL, 32'h1);
		wr(`IDX_CONTROL, 32'h04);
		poll(`IDX_STATUS, `ST_CMD_DONE, 1'b1);
		chk("sent", {24'h0, b}, {24'h0, got_byte});
		$display("test scsi pio done");
		wr(`IDX_CONFIG, 32'h0);
		wr(`IDX_SIGNAL, 32'h2);
		phase <= 3'h2;
		b = 8'(rnd());
		wr(`IDX_OUT_BYTE, {24'h0, b});
		peer_target <= 1'b1;
		wr(`IDX_CONTROL, 32'h04);
		poll(`IDX_STATUS, `ST_CMD_DONE, 1'b1);
		peer_target <= 1'b0;
		chk("init sent", {24'h0, b}, {24'h0, got_byte});
		wr(`IDX_SIGNAL, 32'h1);
		phase <= 3'h4;
		send_byte <= 8'(rnd());
		peer_target <= 1'b1;
		wr(`IDX_CONTROL, 32'h04);
		poll(`IDX_STATUS, `ST_CMD_DONE, 1'b1);
		peer_target <= 1'b0;
		ahb(1'b0, `IDX_CAPTURED, 32'h0, rd);
		chk("init captured", {24'h0, send_byte}, rd);
		$display("test initiator done");
		SCSI_MEM_BUSY <= 1'b1;
		wr(`IDX_CONFIG, 32'h4);
		wr(`IDX_WR_PTR, 32'h200);
		b = 8'(rnd());
		wr(`IDX_MEM_BYTE, {24'h0, b});
		wr(`IDX_CONTROL, 32'h80);
		repeat (20) @(posedge CLK);
		ahb(1'b0, `IDX_CONTROL, 32'h0, rd);
		chk("held", 32'h1, {31'h0, rd[`CT_MEM_GO]});
		SCSI_MEM_BUSY <= 1'b0;
		poll(`IDX_CONTROL, `CT_MEM_GO, 1'b0);
		repeat (40) @(posedge CLK);
		chk("refresh", 32'h1, {31'h0, refr > 0});
		wr(`IDX_RD_PTR, 32'h200);
		wr(`IDX_CONTROL, 32'h81);
		poll(`IDX_CONTROL, `CT_MEM_GO, 1'b0);
		ahb(1'b0, `IDX_MEM_BYTE, 32'h0, rd);
		chk("dram byte", {24'h0, b}, rd);
		ahb(1'b0, `IDX_RD_PTR, 32'h0, rd);
		chk("rptr", 32'h201, rd);
		$display("test dram done");
		wr(`IDX_CONFIG, 32'h2);
		wr(`IDX_SIGNAL, 32'hC0);
		ahb(1'b0, `IDX_STATUS, 32'h0, rd);
		wr(`IDX_CONTROL, 32'h04);
		repeat (20) @(posedge CLK);
		chk("manual", 32'h6, {29'h0, so.bsy, so.sel, so.req});
		ahb(1'b0, `IDX_STATUS, 32'h0, rd);
		chk("nodone", 32'h0, {31'h0, rd[`ST_CMD_DONE]});
		$display("test manual done");
		test_done();
	end
endmodule
